// ==== design/ttc_map.vh ====
// register offsets, field positions and reset values of the triple timer block
`ifndef TTC_MAP_VH
`define TTC_MAP_VH
`define TTC_OFF_MODE      12'h000
`define TTC_OFF_CTRL      12'h004
`define TTC_OFF_CNT0      12'h008
`define TTC_OFF_CNT1      12'h00C
`define TTC_OFF_T3CTRL    12'h010
`define TTC_OFF_T3MODE    12'h014
`define TTC_OFF_T3CNT     12'h018
`define TTC_OFF_T3CAP     12'h01C
`define TTC_OFF_TICK      12'h020
// mode register fields, per timer nibble: gate 3, count select 2, mode 1:0
`define TTC_MODE_GATE1    7
`define TTC_MODE_CSEL1    6
`define TTC_MODE_GATE0    3
`define TTC_MODE_CSEL0    2
// control register fields
`define TTC_CTRL_OVF1     7
`define TTC_CTRL_RUN1     6
`define TTC_CTRL_OVF0     5
`define TTC_CTRL_RUN0     4
// third timer control fields
`define TTC_T3_OVF        7
`define TTC_T3_EXT        6
`define TTC_T3_EXEN       3
`define TTC_T3_RUN        2
`define TTC_T3_CSEL       1
`define TTC_T3_CAPSEL     0
// third timer mode field
`define TTC_T3M_DOWN_COUNT_ENABLE      0
// tick register field: 1 selects twelve clocks per machine cycle
`define TTC_TICK_TWELVE   0
// reset values
`define TTC_RST_BYTE      8'h00
`define TTC_RST_WORD      16'h0000
`define TTC_ALL_ONES      16'hFFFF
// machine cycle dividers in system clocks
`define TTC_DIV_SIX       4'h6
`define TTC_DIV_TWELVE    4'hC
`endif

// ==== design/ttc_pin_sync.v ====
// two-flop synchroniser with falling edge detect for one pin
`timescale 1ns/1ps
module ttc_pin_sync (
  input  wire clk_sys,
  input  wire reset,
  input  wire pin_in,
  output wire level,
  output wire fall
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // the first flop feeds only the second; edges come from later samples
  always @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign fall  = prev_reg & ~sync_reg;
endmodule // ttc_pin_sync

// ==== design/ttc_timers.v ====
// three timer/counters with apb register access
//
// Summary of operation
// - timers 0 and 1 pick one of four modes and timer or counter
// - mode 0 counts 13 bits: high byte plus low five bits of low byte
// - wrap from all ones to zero sets that timer's overflow flag
// - count only when run is set and gate is off or gate pin high
// - setting run keeps the present count
// - gate bit is mode bit 7 for timer 1, bit 3 for timer 0
// - mode 1 counts all 16 bits
// - mode 2 low byte counts, overflow reloads it from the high byte
// - timer 1 in mode 3 holds its count
// - timer 0 mode 3 low byte is own 8-bit counter on timer 0 controls
// - timer 0 mode 3 high byte times cycles with timer 1 run and flag
// - third timer is 16 bits, timing ticks or counting pin events
// - capture mode without external enable counts and flags overflow
// - capture mode: pin falling edge copies count and sets external flag
// - capture does not disturb counting at osc/6 or osc/12
// - both third timer flags readable to find interrupt cause
// - down enable resets to 0; when set the pin sets direction
// - up reload mode: overflow at ffff sets flag and reloads
// - up reload with external enable: pin edge reloads and sets flag
// - up/down, pin high: count up, overflow reloads, sets flag
// - up/down, pin low: underflow at reload value, load ffff, set flag
// - up/down: external flag toggles on each wrap, no interrupt
// - third overflow flag stays set until software clears it
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "ttc_map.vh"
module ttc_timers (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        first_count_pin,
  input  wire        second_count_pin,
  input  wire        first_gate_pin,
  input  wire        second_gate_pin,
  input  wire        third_count_pin,
  input  wire        capture_direction_pin,
  output reg         third_irq_req
);
  // state
  reg  [7:0]  timer_mode_register;
  reg  [7:0]  timer_control_register;
  reg  [7:0]  third_timer_control;
  reg  [7:0]  third_timer_mode;
  reg  [7:0]  tick_cfg_reg;
  reg  [7:0]  first_low_byte;
  reg  [7:0]  first_high_byte;
  reg  [7:0]  second_low_byte;
  reg  [7:0]  second_high_byte;
  reg  [15:0] third_count_reg;
  reg  [15:0] third_cap_reg;
  reg  [3:0]  tick_div_reg;
  reg         tick_reg;

  // count pins act on falling edges only, so their levels stay unread
  wire c0_fall;
  wire c1_fall;
  wire c2_fall;
  wire g0_lvl;
  wire g1_lvl;
  wire dir_lvl;
  wire dir_fall;

  // all pins pass two flops before use
  ttc_pin_sync u_c0 (.clk_sys(clk_sys), .reset(reset),
    .pin_in(first_count_pin), .level(), .fall(c0_fall));
  ttc_pin_sync u_c1 (.clk_sys(clk_sys), .reset(reset),
    .pin_in(second_count_pin), .level(), .fall(c1_fall));
  ttc_pin_sync u_g0 (.clk_sys(clk_sys), .reset(reset),
    .pin_in(first_gate_pin), .level(g0_lvl), .fall());
  ttc_pin_sync u_g1 (.clk_sys(clk_sys), .reset(reset),
    .pin_in(second_gate_pin), .level(g1_lvl), .fall());
  ttc_pin_sync u_c2 (.clk_sys(clk_sys), .reset(reset),
    .pin_in(third_count_pin), .level(), .fall(c2_fall));
  ttc_pin_sync u_dx (.clk_sys(clk_sys), .reset(reset),
    .pin_in(capture_direction_pin), .level(dir_lvl), .fall(dir_fall));

  // machine cycle tick: one clock in six, or twelve in 12-clock mode
  // free running, so any window of whole periods holds the same tick count
  wire [3:0] tick_div_top = tick_cfg_reg[`TTC_TICK_TWELVE] ?
                            `TTC_DIV_TWELVE : `TTC_DIV_SIX;
  always @(posedge clk_sys) begin
    if (reset) begin
      tick_div_reg <= 4'h0;
      tick_reg     <= 1'b0;
    end else if (tick_div_reg >= tick_div_top - 4'h1) begin
      tick_div_reg <= 4'h0;
      tick_reg     <= 1'b1;
    end else begin
      tick_div_reg <= tick_div_reg + 4'h1;
      tick_reg     <= 1'b0;
    end
  end

  // count input: tick when timing, synced pin falling edge when counting
  function cnt_in;
    input csel;
    input tick;
    input pin_fall;
    begin
      cnt_in = csel ? pin_fall : tick;
    end
  endfunction

  // gating: run and (gate off or gate pin high)
  function gated;
    input run;
    input gate;
    input gpin;
    begin
      gated = run & (~gate | gpin);
    end
  endfunction

  wire [1:0] mode0 = timer_mode_register[1:0];
  wire [1:0] mode1 = timer_mode_register[5:4];
  // gate bits at mode bit 3 and 7
  wire en0 = gated(timer_control_register[`TTC_CTRL_RUN0],
    timer_mode_register[`TTC_MODE_GATE0], g0_lvl) &
    cnt_in(timer_mode_register[`TTC_MODE_CSEL0], tick_reg, c0_fall);
  wire en1_raw = gated(timer_control_register[`TTC_CTRL_RUN1],
    timer_mode_register[`TTC_MODE_GATE1], g1_lvl) &
    cnt_in(timer_mode_register[`TTC_MODE_CSEL1], tick_reg, c1_fall);
  // timer 1 in mode 3 holds, as if run were clear
  wire en1 = en1_raw & (mode1 != 2'b11);
  // timer 0 mode 3 high byte: machine cycles gated by timer 1 run
  wire m3 = (mode0 == 2'b11);
  wire en0h = m3 & timer_control_register[`TTC_CTRL_RUN1] & tick_reg;

  // apb decode: access phase is the single completing cycle
  wire wr = psel & penable & pwrite;

  // address match shared by every write select
  function hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // one strobe per register; a write lands only at the completing edge
  wire sel_mode  = wr & hit(paddr, `TTC_OFF_MODE);
  wire sel_ctrl  = wr & hit(paddr, `TTC_OFF_CTRL);
  wire sel_cnt0  = wr & hit(paddr, `TTC_OFF_CNT0);
  wire sel_cnt1  = wr & hit(paddr, `TTC_OFF_CNT1);
  wire sel_t3c   = wr & hit(paddr, `TTC_OFF_T3CTRL);
  wire sel_t3m   = wr & hit(paddr, `TTC_OFF_T3MODE);
  wire sel_t3cnt = wr & hit(paddr, `TTC_OFF_T3CNT);
  wire sel_t3cap = wr & hit(paddr, `TTC_OFF_T3CAP);
  wire sel_tick  = wr & hit(paddr, `TTC_OFF_TICK);

  // one timer's next count for modes 0..2; returns {ovf, high, low}
  function [16:0] step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg   [13:0] s13;
    reg   [16:0] s16;
    begin
      s13 = 14'h0000;
      s16 = 17'h0_0000;
      case (mode)
        2'b00: begin
          s13  = {1'b0, hi, lo[4:0]} + 14'h0001;
          step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
        end
        2'b01: begin
          s16  = {1'b0, hi, lo} + 17'h0_0001;
          step = s16;
        end
        2'b10: begin
          if (lo == 8'hFF)
            step = {1'b1, hi, hi};
          else
            step = {1'b0, hi, lo + 8'h01};
        end
        default: step = {1'b0, hi, lo};
      endcase
    end
  endfunction

  wire [16:0] nx0 = step(mode0, first_high_byte, first_low_byte);
  wire [16:0] nx1 = step(mode1, second_high_byte, second_low_byte);
  wire        ovf0_lo = m3 & en0 & (first_low_byte == 8'hFF);
  wire        ovf0_hi = en0h & (first_high_byte == 8'hFF);
  wire        ovf0 = m3 ? ovf0_lo : (en0 & nx0[16]);
  // with timer 0 in mode 3 its high byte owns the timer 1 flag
  wire        ovf1 = m3 ? ovf0_hi : (en1 & nx1[16]);

  // timers 0 and 1 counters and control; hardware set beats software clear
  always @(posedge clk_sys) begin
    if (reset) begin
      timer_mode_register    <= `TTC_RST_BYTE;
      timer_control_register <= `TTC_RST_BYTE;
      first_low_byte         <= `TTC_RST_BYTE;
      first_high_byte        <= `TTC_RST_BYTE;
      second_low_byte        <= `TTC_RST_BYTE;
      second_high_byte       <= `TTC_RST_BYTE;
    end else begin
      if (sel_mode)
        timer_mode_register <= pwdata[7:0];
      // run bits only steer counting, never clear counts
      if (sel_ctrl)
        timer_control_register <= pwdata[7:0];
      if (ovf0)
        timer_control_register[`TTC_CTRL_OVF0] <= 1'b1;
      if (ovf1)
        timer_control_register[`TTC_CTRL_OVF1] <= 1'b1;
      if (sel_cnt0) begin
        first_low_byte  <= pwdata[7:0];
        first_high_byte <= pwdata[15:8];
      end else if (m3) begin
        if (en0)
          first_low_byte <= first_low_byte + 8'h01;
        if (en0h)
          first_high_byte <= first_high_byte + 8'h01;
      end else if (en0) begin
        first_low_byte  <= nx0[7:0];
        first_high_byte <= nx0[15:8];
      end
      if (sel_cnt1) begin
        second_low_byte  <= pwdata[7:0];
        second_high_byte <= pwdata[15:8];
      end else if (en1) begin
        second_low_byte  <= nx1[7:0];
        second_high_byte <= nx1[15:8];
      end
    end
  end

  // third timer
  wire t3_capmode = third_timer_control[`TTC_T3_CAPSEL];
  wire t3_exen    = third_timer_control[`TTC_T3_EXEN];
  wire t3_down_count_enable    = third_timer_mode[`TTC_T3M_DOWN_COUNT_ENABLE];
  wire t3_en = third_timer_control[`TTC_T3_RUN] &
    cnt_in(third_timer_control[`TTC_T3_CSEL], tick_reg, c2_fall);
  // direction pin steers only in reload mode with down enable
  wire t3_down = ~t3_capmode & t3_down_count_enable & ~dir_lvl;
  wire t3_updn = ~t3_capmode & t3_down_count_enable;
  wire t3_ovf  = t3_en & ~t3_down & (third_count_reg == `TTC_ALL_ONES);
  wire t3_unf  = t3_en & t3_down & (third_count_reg == third_cap_reg);
  // in up/down mode the pin only steers direction: no reload, no flag
  wire t3_edge = t3_exen & dir_fall & ~t3_updn;
  reg  [15:0] t3_next;

  // next count: capture never changes counting
  always @* begin
    t3_next = third_count_reg;
    if (t3_unf)
      t3_next = `TTC_ALL_ONES;
    else if (t3_ovf & ~t3_capmode)
      t3_next = third_cap_reg;
    else if (t3_edge & ~t3_capmode)
      t3_next = third_cap_reg;
    else if (t3_en & t3_down)
      t3_next = third_count_reg - 16'h0001;
    else if (t3_en)
      t3_next = third_count_reg + 16'h0001;
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      third_timer_control <= `TTC_RST_BYTE;
      third_timer_mode    <= `TTC_RST_BYTE;
      tick_cfg_reg        <= `TTC_RST_BYTE;
      third_count_reg     <= `TTC_RST_WORD;
      third_cap_reg       <= `TTC_RST_WORD;
    end else begin
      if (sel_t3c)
        third_timer_control <= pwdata[7:0];
      // overflow flag set by hardware or by a software write, cleared by software
      if (t3_ovf | t3_unf)
        third_timer_control[`TTC_T3_OVF] <= 1'b1;
      // wraps toggle the external flag in up/down mode
      if (t3_updn & (t3_ovf | t3_unf))
        third_timer_control[`TTC_T3_EXT] <=
          ~(sel_t3c ? pwdata[`TTC_T3_EXT]
                    : third_timer_control[`TTC_T3_EXT]);
      else if (t3_edge)
        third_timer_control[`TTC_T3_EXT] <= 1'b1;
      if (sel_t3m)
        third_timer_mode <= pwdata[7:0];
      if (sel_tick)
        tick_cfg_reg <= pwdata[7:0];
      if (sel_t3cnt)
        third_count_reg <= pwdata[15:0];
      else
        third_count_reg <= t3_next;
      if (t3_edge & t3_capmode)
        third_cap_reg <= third_count_reg;
      else if (sel_t3cap)
        third_cap_reg <= pwdata[15:0];
    end
  end

  // readback data for the current address
  reg [31:0] rd_mux;
  reg        rd_bad;
  always @* begin
    rd_bad = 1'b0;
    case (paddr)
      `TTC_OFF_MODE:   rd_mux = {24'h00_0000, timer_mode_register};
      `TTC_OFF_CTRL:   rd_mux = {24'h00_0000, timer_control_register};
      `TTC_OFF_CNT0:   rd_mux = {16'h0000, first_high_byte, first_low_byte};
      `TTC_OFF_CNT1:   rd_mux = {16'h0000, second_high_byte, second_low_byte};
      `TTC_OFF_T3CTRL: rd_mux = {24'h00_0000, third_timer_control};
      `TTC_OFF_T3MODE: rd_mux = {24'h00_0000, third_timer_mode};
      `TTC_OFF_T3CNT:  rd_mux = {16'h0000, third_count_reg};
      `TTC_OFF_T3CAP:  rd_mux = {16'h0000, third_cap_reg};
      `TTC_OFF_TICK:   rd_mux = {24'h00_0000, tick_cfg_reg};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_bad = 1'b1;
      end
    endcase
  end

  // apb answer: pready one cycle after setup, so every access takes two
  always @(posedge clk_sys) begin
    if (reset) begin
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      third_irq_req <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rd_bad;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      // either third timer flag asks; in up/down mode only the overflow flag asks
      third_irq_req <= third_timer_control[`TTC_T3_OVF] |
        (third_timer_control[`TTC_T3_EXT] & ~t3_updn);
    end
  end
endmodule // ttc_timers

// ==== verif/ttc_pin_model.sv ====
// external count, gate and capture pins seen by the timer block
`timescale 1ns/1ps
module ttc_pin_model (
  input  wire clk_sys,
  output wire first_count_pin,
  output wire second_count_pin,
  output wire first_gate_pin,
  output wire second_gate_pin,
  output wire third_count_pin,
  output wire capture_direction_pin
);
  reg [5:0] lvl = 6'h3F;
  // pins idle high; gates high let counting through
  assign first_count_pin       = lvl[0];
  assign second_count_pin      = lvl[1];
  assign first_gate_pin        = lvl[2];
  assign second_gate_pin       = lvl[3];
  assign third_count_pin       = lvl[4];
  assign capture_direction_pin = lvl[5];
  // a pin only moves just after a rising edge
  task set_pin(input integer i, input reg v);
    @(posedge clk_sys);
    lvl[i] <= v;
  endtask
  // levels held long so the synced samples see every edge
  task pulse(input integer i, input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) begin
      set_pin(i, 1'b0);
      repeat (24) @(posedge clk_sys);
      set_pin(i, 1'b1);
      repeat (24) @(posedge clk_sys);
    end
  endtask
endmodule // ttc_pin_model

// ==== verif/ttc_timers_sva.sv ====
// port checker for the triple timer block
`timescale 1ns/1ps
module ttc_timers_sva (
  input wire        clk_sys,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        third_irq_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // a setup cycle opens every transfer; map ends at the tick register
  sequence s_setup; psel && !penable; endsequence
  sequence s_map; s_setup ##0 (paddr <= 12'h020 && paddr[1:0] == 2'b00);
  endsequence
  sequence s_unmap; s_setup ##0 (paddr > 12'h020); endsequence
  property p_answer; s_setup |=> pready && psel && penable; endproperty
  property p_single; pready |=> !pready; endproperty
  property p_cause; pready |-> $past(psel && !penable); endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  property p_unmap; s_unmap |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  property p_map; s_map |=> !pslverr; endproperty
  // pready and third_irq_req quiet at the first edge after reset
  property p_rst; $past(reset) |-> !pready && !third_irq_req; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_single: assert property (p_single) else $error("long ready");
  a_cause: assert property (p_cause) else $error("stray ready");
  a_err: assert property (p_err) else $error("stray error");
  a_idle: assert property (p_idle) else $error("data idle");
  a_unmap: assert property (p_unmap) else $error("unmapped");
  a_map: assert property (p_map) else $error("mapped error");
  a_rst: assert property (p_rst) else $error("reset out");
endmodule // ttc_timers_sva

bind ttc_timers ttc_timers_sva u_sva (.clk_sys(clk_sys), .reset(reset),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .third_irq_req(third_irq_req));

// ==== verif/ttc_timers_tb.sv ====
// self-checking bench for the triple timer block
`timescale 1ns/1ps
`include "ttc_map.vh"
module ttc_timers_tb;
  reg         clk_sys = 1'b0;
  reg         reset   = 1'b1;
  reg         psel    = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite  = 1'b0;
  reg  [11:0] paddr   = 12'h000;
  reg  [31:0] pwdata  = 32'h0000_0000;
  reg  [31:0] rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        irq;
  wire        c0, c1, g0, g1, c2, cd;
  integer     fails = 0;
  integer     n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  ttc_pin_model pin (.clk_sys(clk_sys), .first_count_pin(c0),
    .second_count_pin(c1), .first_gate_pin(g0), .second_gate_pin(g1),
    .third_count_pin(c2), .capture_direction_pin(cd));
  ttc_timers uut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_count_pin(c0), .second_count_pin(c1), .first_gate_pin(g0),
    .second_gate_pin(g1), .third_count_pin(c2),
    .capture_direction_pin(cd), .third_irq_req(irq));
  // one apb transfer; read data taken at the completing edge
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    integer k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    while (k < 50) begin
      @(posedge clk_sys);
      if (pready === 1'b1) k = 99;
      else k = k + 1;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      fails = fails + 1;
      give_verdict;
    end
  endtask
  task cmp(input reg [31:0] got, input reg [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task w(input reg [11:0] a, input reg [31:0] d);
    apb(1'b1, a, d);
  endtask
  task c(input reg [11:0] a, input reg [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rd, e);
  endtask
  task t_reset;
    c(`TTC_OFF_MODE, 32'h0000_0000);
    c(`TTC_OFF_CTRL, 32'h0000_0000);
    c(`TTC_OFF_T3MODE, 32'h0000_0000);
    c(`TTC_OFF_T3CNT, 32'h0000_0000);
    cmp({31'h0000_0000, err}, 32'h0000_0000);
    w(12'h024, 32'hFFFF_FFFF);
    c(12'h024, 32'h0000_0000);
    cmp({31'h0000_0000, err}, 32'h0000_0001);
  endtask
  // timer 0 modes 1, 0 and 2 counting pin edges, with gating
  task t_t0;
    w(`TTC_OFF_MODE, 32'h0000_0005);
    w(`TTC_OFF_CNT0, 32'h0000_FFFE);
    w(`TTC_OFF_CTRL, 32'h0000_0010);
    c(`TTC_OFF_CNT0, 32'h0000_FFFE);
    pin.pulse(0, 2);
    c(`TTC_OFF_CNT0, 32'h0000_0000);
    c(`TTC_OFF_CTRL, 32'h0000_0030);
    w(`TTC_OFF_MODE, 32'h0000_000D);
    pin.set_pin(2, 1'b0);
    pin.pulse(0, 1);
    c(`TTC_OFF_CNT0, 32'h0000_0000);
    pin.set_pin(2, 1'b1);
    pin.pulse(0, 1);
    c(`TTC_OFF_CNT0, 32'h0000_0001);
    w(`TTC_OFF_MODE, 32'h0000_0004);
    w(`TTC_OFF_CTRL, 32'h0000_0010);
    w(`TTC_OFF_CNT0, 32'h0000_FFFF);
    pin.pulse(0, 1);
    c(`TTC_OFF_CNT0, 32'h0000_00E0);
    c(`TTC_OFF_CTRL, 32'h0000_0030);
    w(`TTC_OFF_MODE, 32'h0000_0006);
    w(`TTC_OFF_CTRL, 32'h0000_0010);
    w(`TTC_OFF_CNT0, 32'h0000_80FF);
    pin.pulse(0, 1);
    c(`TTC_OFF_CNT0, 32'h0000_8080);
    c(`TTC_OFF_CTRL, 32'h0000_0030);
    pin.pulse(0, 1);
    c(`TTC_OFF_CNT0, 32'h0000_8081);
  endtask
  // mode 3 on both timers
  task t_m3;
    w(`TTC_OFF_CTRL, 32'h0000_0040);
    w(`TTC_OFF_MODE, 32'h0000_0070);
    w(`TTC_OFF_CNT1, 32'h0000_0010);
    pin.pulse(1, 2);
    c(`TTC_OFF_CNT1, 32'h0000_0010);
    w(`TTC_OFF_MODE, 32'h0000_0050);
    pin.pulse(1, 2);
    c(`TTC_OFF_CNT1, 32'h0000_0012);
    w(`TTC_OFF_MODE, 32'h0000_00D0);
    pin.set_pin(3, 1'b0);
    pin.pulse(1, 1);
    c(`TTC_OFF_CNT1, 32'h0000_0012);
    pin.set_pin(3, 1'b1);
    w(`TTC_OFF_CTRL, 32'h0000_0010);
    w(`TTC_OFF_MODE, 32'h0000_0057);
    w(`TTC_OFF_CNT0, 32'h0000_00FF);
    pin.pulse(0, 1);
    c(`TTC_OFF_CNT0, 32'h0000_0000);
    c(`TTC_OFF_CTRL, 32'h0000_0030);
    w(`TTC_OFF_CNT0, 32'h0000_FF00);
    w(`TTC_OFF_CTRL, 32'h0000_0040);
    repeat (20) @(posedge clk_sys);
    c(`TTC_OFF_CTRL, 32'h0000_00C0);
  endtask
  // third timer: capture, up reload, then up/down
  task t_t3;
    w(`TTC_OFF_T3CNT, 32'h0000_FFFE);
    w(`TTC_OFF_T3CTRL, 32'h0000_000F);
    pin.pulse(4, 3);
    c(`TTC_OFF_T3CNT, 32'h0000_0001);
    c(`TTC_OFF_T3CTRL, 32'h0000_008F);
    pin.pulse(5, 1);
    c(`TTC_OFF_T3CAP, 32'h0000_0001);
    cmp({31'h0000_0000, irq}, 32'h0000_0001);
    pin.pulse(4, 1);
    c(`TTC_OFF_T3CNT, 32'h0000_0002);
    c(`TTC_OFF_T3CTRL, 32'h0000_00CF);
    w(`TTC_OFF_T3CAP, 32'h0000_1234);
    w(`TTC_OFF_T3CTRL, 32'h0000_000E);
    w(`TTC_OFF_T3CNT, 32'h0000_FFFF);
    pin.pulse(4, 1);
    c(`TTC_OFF_T3CNT, 32'h0000_1234);
    c(`TTC_OFF_T3CTRL, 32'h0000_008E);
    pin.pulse(4, 1);
    pin.pulse(5, 1);
    c(`TTC_OFF_T3CNT, 32'h0000_1234);
    c(`TTC_OFF_T3CTRL, 32'h0000_00CE);
    w(`TTC_OFF_T3CTRL, 32'h0000_0002);
    w(`TTC_OFF_T3MODE, 32'h0000_0001);
    w(`TTC_OFF_T3CNT, 32'h0000_FFFF);
    w(`TTC_OFF_T3CTRL, 32'h0000_0006);
    pin.pulse(4, 1);
    c(`TTC_OFF_T3CNT, 32'h0000_1234);
    c(`TTC_OFF_T3CTRL, 32'h0000_00C6);
    pin.set_pin(5, 1'b0);
    w(`TTC_OFF_T3CTRL, 32'h0000_0046);
    // the request trails the flags by one registered stage
    repeat (2) @(posedge clk_sys);
    cmp({31'h0000_0000, irq}, 32'h0000_0000);
    w(`TTC_OFF_T3CNT, 32'h0000_1235);
    pin.pulse(4, 1);
    c(`TTC_OFF_T3CNT, 32'h0000_1234);
    pin.pulse(4, 1);
    c(`TTC_OFF_T3CNT, 32'h0000_FFFF);
    c(`TTC_OFF_T3CTRL, 32'h0000_0086);
    pin.set_pin(5, 1'b1);
  endtask
  // third timer timing: 60 counted edges hold whole tick periods
  task t_tick;
    w(`TTC_OFF_T3CNT, 32'h0000_0000);
    w(`TTC_OFF_T3CTRL, 32'h0000_0004);
    repeat (57) @(posedge clk_sys);
    w(`TTC_OFF_T3CTRL, 32'h0000_0000);
    c(`TTC_OFF_T3CNT, 32'h0000_000A);
    w(`TTC_OFF_TICK, 32'h0000_0001);
    w(`TTC_OFF_T3CNT, 32'h0000_0000);
    w(`TTC_OFF_T3CTRL, 32'h0000_0004);
    repeat (57) @(posedge clk_sys);
    w(`TTC_OFF_T3CTRL, 32'h0000_0000);
    c(`TTC_OFF_T3CNT, 32'h0000_0005);
  endtask
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reset for 12 cycles, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_t0;
    t_m3;
    t_t3;
    t_tick;
    give_verdict;
  end
endmodule // ttc_timers_tb
